/* rtl/mmsp_pkg.sv */
// monitor serial port: constants, command opcodes and types
package mmsp_pkg;
    localparam int          CLK_HZ        = 200_000_000;
    localparam int          XTAL_HZ       = 9_830_400;
    localparam int          XTAL_DIV      = 1024;
    localparam int          BAUD          = XTAL_HZ / XTAL_DIV;
    localparam int          BIT_CYC       = CLK_HZ / BAUD;
    localparam int          GAP_BITS      = 2;
    localparam int          CANCEL_BITS   = 11;
    localparam int          BREAK_BITS    = 10;
    localparam int          FRAME_BITS    = 10;
    localparam int          FIFO_DEPTH    = 8;
    localparam logic [15:0] VEC_RST_USER  = 16'hFFFE;
    localparam logic [15:0] VEC_SOFT_USER = 16'hFFFC;
    localparam logic [15:0] VEC_RST_MON   = 16'hFEFE;
    localparam logic [15:0] VEC_SOFT_MON  = 16'hFEFC;
    localparam logic [7:0]  OP_READ       = 8'h4A;
    localparam logic [7:0]  OP_WRITE      = 8'h49;
    localparam logic [7:0]  OP_IDX_READ   = 8'h1A;
    localparam logic [7:0]  OP_IDX_WRITE  = 8'h19;
    localparam logic [7:0]  OP_SP_READ    = 8'h0C;
    localparam logic [7:0]  OP_RUN        = 8'h28;

    typedef enum logic [2:0] {
        S_BOOT, S_IDLE, S_GAP, S_TX, S_WAIT, S_MEM, S_RESP
    } mmsp_state_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mmsp_mem_t;

    typedef struct packed {
        logic [15:0] rst_vec;
        logic [15:0] soft_vec;
        logic        wdog_en;
    } mmsp_mode_t;
endpackage : mmsp_pkg

/* rtl/mmsp_monitor_port.sv */
// monitor serial port engine with its receive fifo
`timescale 1ns/1ps
`default_nettype none

module mmsp_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         n;
    } mmsp_fifo_st_t;

    mmsp_fifo_st_t q;
    mmsp_fifo_st_t d;
    logic          wr;
    logic          rd;

    assign in_ready  = q.n != (AW+1)'(D);
    assign out_valid = q.n != '0;
    assign out_data  = q.mem[q.rp];
    assign wr        = in_valid && in_ready;
    assign rd        = out_valid && out_ready;

    always_comb begin
        d = q;
        if (wr) begin
            d.mem[q.wp] = in_data;
            d.wp = (q.wp == AW'(D-1)) ? '0 : AW'(q.wp + 1'b1);
        end
        if (rd) begin
            d.rp = (q.rp == AW'(D-1)) ? '0 : AW'(q.rp + 1'b1);
        end
        if (wr && !rd) begin
            d.n = (AW+1)'(q.n + 1'b1);
        end else if (rd && !wr) begin
            d.n = (AW+1)'(q.n - 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
        q.n <= (AW+1)'(D))
        else $error("fifo count above depth");
endmodule : mmsp_fifo

////////////////////////////////////////////////////////////////////////////////

module mmsp_monitor_port
    import mmsp_pkg::*;
#(
    parameter int BIT_CYCLES = mmsp_pkg::BIT_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        pin_i,
    output logic             pin_o,
    output logic             pin_oe,
    input  wire logic        hv_irq_i,
    input  wire logic        monitor_mode,
    input  wire logic        watchdog_disable_bit,
    input  wire logic        security_ok,
    input  wire logic [15:0] sp_i,
    input  wire logic        mem_ack,
    input  wire logic [7:0]  mem_rdata,
    output mmsp_mem_t        mem,
    output mmsp_mode_t       mode,
    output logic             pull_index_high,
    output logic             return_from_interrupt
);
    localparam logic [23:0] B1   = 24'(BIT_CYCLES - 1);
    localparam logic [23:0] HALF = 24'(BIT_CYCLES / 2);
    localparam logic [23:0] GAP  = 24'(GAP_BITS * BIT_CYCLES - 1);
    localparam logic [23:0] CW   = 24'(CANCEL_BITS * BIT_CYCLES - 1);

    typedef struct packed {
        mmsp_state_t st;
        mmsp_state_t ret;
        logic [23:0] tmr;
        logic [3:0]  nb;
        logic [9:0]  tsh;
        logic        oe;
        logic        po;
        logic [7:0]  cmd;
        logic [1:0]  cnt;
        logic [15:0] addr;
        logic [7:0]  wdat;
        logic [15:0] resp;
        logic [1:0]  nresp;
        logic [1:0]  rdl;
        logic        rbusy;
        logic        rarm;
        logic [23:0] rtm;
        logic [3:0]  rbit;
        logic [9:0]  rsh;
        logic        brk;
        logic        pv;
        logic [7:0]  pd;
        mmsp_mem_t   mem;
        mmsp_mode_t  mode;
        logic        pih;
        logic        rfi;
        logic [1:0]  sp;
        logic [1:0]  sh;
    } mmsp_st_t;

    // operand count per command, 7 marks an unknown opcode
    function automatic logic [2:0] need_of(input logic [7:0] op);
        unique case (op)
            OP_READ:   need_of = 3'd2;
            OP_WRITE:  need_of = 3'd3;
            OP_IDX_WRITE: need_of = 3'd1;
            OP_IDX_READ,
            OP_SP_READ,
            OP_RUN:    need_of = 3'd0;
            default:   need_of = 3'd7;
        endcase
    endfunction : need_of

    mmsp_st_t    q;
    mmsp_st_t    d;
    logic        pop;
    logic        go;
    logic [9:0]  fr;
    mmsp_state_t rt;
    logic [7:0]  op;
    logic [2:0]  nd;
    logic [9:0]  n;
    logic        line;
    logic        fo_v;
    logic [7:0]  fo_d;
    logic        in_rdy;

    // rx cannot be paused, so a full fifo only holds off the next start bit
    mmsp_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (q.pv),
        .in_ready  (in_rdy),
        .in_data   (q.pd),
        .out_valid (fo_v),
        .out_ready (pop),
        .out_data  (fo_d)
    );

    assign line = q.sp[1];

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        d     = q;
        pop   = 1'b0;
        go    = 1'b0;
        fr    = '0;
        rt    = S_IDLE;
        op    = '0;
        nd    = '0;
        n     = '0;
        d.pv  = 1'b0;
        d.pih = 1'b0;
        d.po  = 1'b0;
        d.rfi = q.pih;
        d.sp  = {q.sp[0], pin_i};
        d.sh  = {q.sh[0], hv_irq_i};
        d.mode.rst_vec = monitor_mode ? VEC_RST_MON : VEC_RST_USER;
        d.mode.soft_vec = monitor_mode ? VEC_SOFT_MON : VEC_SOFT_USER;
        d.mode.wdog_en = !watchdog_disable_bit && (!monitor_mode || !q.sh[1]);
        unique case (q.st)
            S_BOOT: begin
                if (security_ok) begin
                    go = 1'b1;
                end
            end
            S_IDLE: begin
                if (q.brk) begin
                    d.brk = 1'b0;
                    d.cnt = '0;
                    go    = 1'b1;
                end else if (fo_v) begin
                    pop = 1'b1;
                    go  = 1'b1;
                    fr  = {1'b1, fo_d, 1'b0};
                    op  = (q.cnt == 2'd0) ? fo_d : q.cmd;
                    nd  = need_of(op);
                    if (q.cnt == 2'd0) begin
                        d.cmd = fo_d;
                    end
                    if (q.cnt == 2'd1 && op == OP_IDX_WRITE) begin
                        d.wdat = fo_d;
                    end else if (q.cnt == 2'd1) begin
                        d.addr[15:8] = fo_d;
                    end else if (q.cnt == 2'd2) begin
                        d.addr[7:0] = fo_d;
                    end else if (q.cnt == 2'd3) begin
                        d.wdat = fo_d;
                    end
                    if (nd == 3'd7) begin
                        d.cnt = '0;
                    end else if ({1'b0, q.cnt} == nd) begin
                        d.cnt = '0;
                        rt    = S_WAIT;
                    end else begin
                        d.cnt = 2'(q.cnt + 1'b1);
                    end
                end
            end
            S_GAP: begin
                if (q.tmr != '0) begin
                    d.tmr = 24'(q.tmr - 1'b1);
                end else begin
                    d.st  = S_TX;
                    d.tmr = B1;
                end
            end
            S_TX: begin
                if (q.tmr != '0) begin
                    d.tmr = 24'(q.tmr - 1'b1);
                end else begin
                    d.tsh = {1'b1, q.tsh[9:1]};
                    d.tmr = B1;
                    d.nb  = 4'(q.nb - 1'b1);
                    if (q.nb == 4'd1) begin
                        d.st  = q.ret;
                        d.tmr = CW;
                    end
                end
            end
            S_WAIT: begin
                if (q.brk) begin
                    d.st = S_IDLE;
                end else if (q.tmr != '0) begin
                    d.tmr = 24'(q.tmr - 1'b1);
                end else begin
                    d.st = S_MEM;
                    d.rdl = '0;
                    d.nresp = '0;
                    d.mem = '{req: 1'b1, we: 1'b0, addr: q.addr, wdata: q.wdat};
                    unique case (q.cmd)
                        OP_READ: begin
                            d.rdl   = 2'd1;
                            d.nresp = 2'd1;
                        end
                        OP_WRITE: begin
                            d.mem.we = 1'b1;
                        end
                        OP_IDX_READ: begin
                            d.addr     = 16'(q.addr + 1'b1);
                            d.mem.addr = 16'(q.addr + 1'b1);
                            d.rdl      = 2'd2;
                            d.nresp    = 2'd2;
                        end
                        OP_IDX_WRITE: begin
                            d.addr     = 16'(q.addr + 1'b1);
                            d.mem.addr = 16'(q.addr + 1'b1);
                            d.mem.we   = 1'b1;
                        end
                        OP_SP_READ: begin
                            d.mem.req = 1'b0;
                            d.resp    = 16'(sp_i + 1'b1);
                            d.nresp   = 2'd2;
                            d.st      = S_RESP;
                        end
                        default: begin
                            d.mem.req = 1'b0;
                            d.pih     = 1'b1;
                            d.st      = S_IDLE;
                        end
                    endcase
                end
            end
            S_MEM: begin
                if (mem_ack) begin
                    d.mem.req = 1'b0;
                    d.st      = S_RESP;
                    if (q.rdl != '0) begin
                        d.resp = {q.resp[7:0], mem_rdata};
                        d.rdl  = 2'(q.rdl - 1'b1);
                    end
                    if (q.rdl == 2'd2) begin
                        d.addr     = 16'(q.addr + 1'b1);
                        d.mem.addr = 16'(q.addr + 1'b1);
                        d.mem.req  = 1'b1;
                        d.st       = S_MEM;
                    end
                end
            end
            S_RESP: begin
                if (q.nresp == '0) begin
                    d.st = S_IDLE;
                end else begin
                    go      = 1'b1;
                    rt      = S_RESP;
                    fr      = {1'b1, (q.nresp == 2'd2) ? q.resp[15:8] : q.resp[7:0], 1'b0};
                    d.nresp = 2'(q.nresp - 1'b1);
                end
            end
        endcase
        if (go) begin
            d.st  = S_GAP;
            d.tmr = GAP;
            d.tsh = fr;
            d.nb  = 4'(FRAME_BITS);
            d.ret = rt;
            if (fr == '0) begin
                d.nb = 4'(BREAK_BITS);
            end
        end
        // receiver; own transmission is not heard, the pin is half duplex
        if (line) begin
            d.rarm = 1'b1;
        end
        if (!q.rbusy) begin
            if (!line && q.rarm && q.st != S_TX && in_rdy) begin
                d.rbusy = 1'b1;
                d.rtm   = HALF;
                d.rbit  = '0;
            end
        end else if (q.rtm != '0) begin
            d.rtm = 24'(q.rtm - 1'b1);
        end else begin
            n      = {line, q.rsh[9:1]};
            d.rsh  = n;
            d.rtm  = B1;
            d.rbit = 4'(q.rbit + 1'b1);
            if (q.rbit == 4'd0 && line) begin
                d.rbusy = 1'b0;
            end else if (q.rbit == 4'd9) begin
                d.rbusy = 1'b0;
                if (n == '0) begin
                    d.brk  = 1'b1;
                    d.rarm = 1'b0;
                end else if (n[9]) begin
                    d.pv = 1'b1;
                    d.pd = n[8:1];
                end
            end
        end
        d.oe = (d.st == S_TX) && !d.tsh[0];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pin_o                 = q.po;
    assign pin_oe                = q.oe;
    assign mem                   = q.mem;
    assign mode                  = q.mode;
    assign pull_index_high       = q.pih;
    assign return_from_interrupt = q.rfi;

    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [23:0] rel_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rel_q <= '0;
        end else if (q.oe) begin
            rel_q <= '0;
        end else if (rel_q != 24'hFFFFFF) begin
            rel_q <= 24'(rel_q + 1'b1);
        end
    end

    sequence s_pull;
        pull_index_high;
    endsequence

    sequence s_rfi;
        return_from_interrupt && !pull_index_high;
    endsequence

    a_vec_user: assert property (!monitor_mode |=> mode.rst_vec == VEC_RST_USER
        && mode.soft_vec == VEC_SOFT_USER)
        else $error("user vectors wrong");
    a_vec_mon: assert property (monitor_mode |=> mode.rst_vec == VEC_RST_MON
        && mode.soft_vec == VEC_SOFT_MON)
        else $error("monitor vectors wrong");
    a_wdog_hv_off: assert property (monitor_mode && !q.sh[1] && !watchdog_disable_bit
        |=> mode.wdog_en)
        else $error("watchdog not enabled after high voltage removal");
    a_wdog_mask: assert property (watchdog_disable_bit |=> !mode.wdog_en)
        else $error("watchdog enabled while disabled");
    // only the start bit counts; low data bits inside a frame raise the enable too
    a_gap_before_tx: assert property ($rose(q.oe) && q.nb == 4'(FRAME_BITS)
        |-> rel_q >= 24'(GAP_BITS * BIT_CYCLES))
        else $error("transmission started without two idle bits");
    a_start_low: assert property (q.st == S_GAP && d.st == S_TX |=> pin_oe)
        else $error("start bit not driven low");
    a_break_low: assert property (q.st == S_TX && q.tsh == '0 |-> pin_oe)
        else $error("break bit not driven low");
    a_echo_byte: assert property (pop |=> q.st == S_GAP && q.tsh[8:1] == $past(fo_d))
        else $error("echo does not match received byte");
    a_cancel_cmd: assert property (q.st == S_WAIT && q.brk |=> q.st == S_IDLE
        && !q.mem.req && !pull_index_high)
        else $error("break did not cancel the command");
    a_run_order: assert property (s_pull |=> s_rfi)
        else $error("return from interrupt not after index pull");
endmodule : mmsp_monitor_port

`default_nettype wire

/* verif/mmsp_host_model.sv */
// host side of the monitor link: open-drain driver, frame receiver, pull-up
`timescale 1ns/1ps
`default_nettype none

module mmsp_host_model #(
    parameter int BIT = 16
) (
    input  wire logic clk,
    input  wire logic dev_oe,
    output logic      line
);
    logic        host_oe = 1'b0;
    int unsigned cyc     = 0;
    int unsigned hi_run  = 0;

    // pull-up: the wire is high unless either side pulls it down
    assign line = !(dev_oe || host_oe);

    always @(posedge clk) begin
        cyc    <= cyc + 1;
        hi_run <= line ? hi_run + 1 : 0;
    end

    ////////////////////////////////////////////////////////////////////////////////

    // a break keeps the data and stop bits low as well
    task automatic send(input logic [7:0] b, input logic brk);
        logic [9:0] f;
        f = brk ? 10'h000 : {1'b1, b, 1'b0};
        @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            host_oe <= !f[i];
            repeat (BIT) @(posedge clk);
        end
        host_oe <= 1'b0;
    endtask : send

    // samples at mid-bit so the edge race with the driver never matters
    task automatic recv(output logic [7:0] b, output logic stp,
                        output int unsigned t0, output int unsigned gap);
        int unsigned n;
        n = 0;
        // let our own release reach the wire before looking for a start bit
        @(posedge clk);
        while (line && n < 80 * BIT) begin
            @(posedge clk);
            n++;
        end
        gap = hi_run;
        t0  = cyc;
        b   = 'x;
        stp = 1'bx;
        if (line) return;
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            b[i] = line;
        end
        repeat (BIT) @(posedge clk);
        stp = line;
    endtask : recv
endmodule : mmsp_host_model

`default_nettype wire

/* verif/tb.sv */
// self-checking bench for the monitor serial port
`timescale 1ns/1ps
`default_nettype none

module tb
    import mmsp_pkg::*;
;
    localparam int BIT = 16;

    logic        clk                  = 1'b0;
    logic        rst_n                = 1'b0;
    logic        line;
    logic        pin_o;
    logic        pin_oe;
    logic        hv_irq_i             = 1'b1;
    logic        monitor_mode         = 1'b1;
    logic        watchdog_disable_bit = 1'b0;
    logic        security_ok          = 1'b0;
    logic [15:0] sp_i                 = 16'h00F9;
    logic        mem_ack              = 1'b0;
    logic [7:0]  mem_rdata            = 8'h00;
    mmsp_mem_t   mem;
    mmsp_mode_t  mode;
    logic        pull_index_high;
    logic        return_from_interrupt;
    logic [24:0] mlog [$];
    int unsigned dly, cyc, t_pih, t_rfi, n_pih, t_end;
    int unsigned failures = 0;
    int unsigned n_checks = 0;

    always #2.5 clk = !clk;

    mmsp_monitor_port #(
        .BIT_CYCLES (BIT)
    ) dut_u (
        .clk                   (clk),
        .rst_n                 (rst_n),
        .pin_i                 (line),
        .pin_o                 (pin_o),
        .pin_oe                (pin_oe),
        .hv_irq_i              (hv_irq_i),
        .monitor_mode          (monitor_mode),
        .watchdog_disable_bit  (watchdog_disable_bit),
        .security_ok           (security_ok),
        .sp_i                  (sp_i),
        .mem_ack               (mem_ack),
        .mem_rdata             (mem_rdata),
        .mem                   (mem),
        .mode                  (mode),
        .pull_index_high       (pull_index_high),
        .return_from_interrupt (return_from_interrupt)
    );

    mmsp_host_model #(.BIT(BIT)) host_u (.clk(clk), .dev_oe(pin_oe), .line(line));

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic [7:0] rd(input logic [15:0] a);
        return a[15:8] ^ a[7:0] ^ 8'hA5;
    endfunction : rd

    // memory answers two cycles late so a held request is really exercised
    always @(posedge clk) begin
        cyc     <= cyc + 1;
        mem_ack <= mem.req && !mem_ack && dly == 2;
        dly     <= (mem.req && !mem_ack && dly != 2) ? dly + 1 : 0;
        if (mem.req && !mem_ack && dly == 2) begin
            mem_rdata <= rd(mem.addr);
            mlog.push_back({mem.we, mem.addr, mem.wdata});
        end
        if (pull_index_high) begin
            n_pih <= n_pih + 1;
            t_pih <= cyc;
        end
        if (return_from_interrupt) t_rfi <= cyc;
    end

    ////////////////////////////////////////////////////////////////////////////////

    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic chk_req(input logic we, input logic [15:0] a, input logic [7:0] d);
        logic [24:0] e;
        e = (mlog.size() > 0) ? mlog.pop_front() : 'x;
        chk(e[24:8], {we, a});
        if (we) chk(e[7:0], d);
    endtask : chk_req

    task automatic cmd(input logic [7:0] q[$]);
        logic [7:0]  r;
        logic        s;
        int unsigned t, g;
        foreach (q[i]) begin
            host_u.send(q[i], 1'b0);
            host_u.recv(r, s, t, g);
            chk(r, q[i]);
            chk(s, 1'b1);
            chk(g >= 2 * BIT - 2, 1'b1);
            t_end = t + 10 * BIT;
            repeat (3 * BIT / 2) @(posedge clk);
        end
    endtask : cmd

    task automatic rx(input logic [7:0] exp, input int unsigned min_bits);
        logic [7:0]  r;
        logic        s;
        int unsigned t, g;
        host_u.recv(r, s, t, g);
        chk({r, s}, {exp, 1'b1});
        chk(t >= t_end + min_bits * BIT, 1'b1);
        t_end = t + 10 * BIT;
        repeat (3 * BIT / 2) @(posedge clk);
    endtask : rx

    ////////////////////////////////////////////////////////////////////////////////

    // bytes queue up during boot; the ninth finds the fifo full and is lost
    task automatic t_boot_fifo();
        logic [7:0]  r;
        logic        s;
        int unsigned t, g;
        for (int i = 0; i < 9; i++) host_u.send(8'h80 + 8'(i), 1'b0);
        security_ok <= 1'b1;
        host_u.recv(r, s, t, g);
        chk({r, s}, 9'h000);
        repeat (BIT) @(posedge clk);
        chk(line, 1'b1);
        for (int i = 0; i < 8; i++) begin
            host_u.recv(r, s, t, g);
            chk({r, s}, {8'h80 + 8'(i), 1'b1});
            chk(g >= 2 * BIT - 2, 1'b1);
        end
        repeat (30 * BIT) @(posedge clk);
        chk(host_u.hi_run >= 28 * BIT, 1'b1);
        chk(mlog.size(), 0);
    endtask : t_boot_fifo

    task automatic t_read();
        cmd('{OP_READ, 8'h12, 8'h34});
        rx(rd(16'h1234), 13);
        chk_req(1'b0, 16'h1234, 8'h00);
    endtask : t_read

    task automatic t_write();
        cmd('{OP_WRITE, 8'hFF, 8'hFF, 8'h3C});
        repeat (14 * BIT) @(posedge clk);
        chk_req(1'b1, 16'hFFFF, 8'h3C);
    endtask : t_write

    // pointer sits at the top of memory, so the step must wrap
    task automatic t_idx_read();
        cmd('{OP_IDX_READ});
        rx(rd(16'h0000), 13);
        rx(rd(16'h0001), 2);
        chk_req(1'b0, 16'h0000, 8'h00);
        chk_req(1'b0, 16'h0001, 8'h00);
    endtask : t_idx_read

    task automatic t_idx_write();
        cmd('{OP_IDX_WRITE, 8'hC3});
        repeat (14 * BIT) @(posedge clk);
        chk_req(1'b1, 16'h0002, 8'hC3);
    endtask : t_idx_write

    task automatic t_sp_read();
        cmd('{OP_SP_READ});
        rx(8'h00, 13);
        rx(8'hFA, 2);
        chk(mlog.size(), 0);
    endtask : t_sp_read

    task automatic t_run();
        cmd('{OP_RUN});
        repeat (14 * BIT) @(posedge clk);
        chk(n_pih, 1);
        chk(t_rfi, t_pih + 1);
    endtask : t_run

    // a break inside the closing wait must kill the pending read
    task automatic t_cancel();
        logic [7:0]  r;
        logic        s;
        int unsigned t, g;
        cmd('{OP_READ, 8'h00, 8'h10});
        host_u.send(8'h00, 1'b1);
        host_u.recv(r, s, t, g);
        chk({r, s}, 9'h000);
        chk(g >= BIT, 1'b1);
        repeat (BIT) @(posedge clk);
        chk(line, 1'b1);
        repeat (20 * BIT) @(posedge clk);
        chk(mlog.size(), 0);
    endtask : t_cancel

    task automatic t_mode();
        logic [2:0] tbl [5];
        logic       mon, hv, dis;
        tbl = '{3'b110, 3'b100, 3'b101, 3'b000, 3'b001};
        foreach (tbl[i]) begin
            {mon, hv, dis} = tbl[i];
            monitor_mode         <= mon;
            hv_irq_i             <= hv;
            watchdog_disable_bit <= dis;
            repeat (6) @(posedge clk);
            chk(mode.rst_vec, mon ? 16'hFEFE : 16'hFFFE);
            chk(mode.soft_vec, mon ? 16'hFEFC : 16'hFFFC);
            chk(pin_o, 1'b0);
            chk(mode.wdog_en, !dis && !(mon && hv));
        end
    endtask : t_mode

    ////////////////////////////////////////////////////////////////////////////////

    task automatic final_report();
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (4) @(posedge clk);
        chk(pin_oe, 1'b0);
        chk(pin_o, 1'b0);
        chk(BAUD, 9600);
        chk(14_745_600 / XTAL_DIV, 14400);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_boot_fifo();
        t_read();
        t_write();
        t_idx_read();
        t_idx_write();
        t_sp_read();
        t_run();
        t_cancel();
        t_mode();
        final_report();
    end

    // whole run needs about 12k cycles
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        final_report();
    end
endmodule : tb

`default_nettype wire
